// *** logic/dual_flop_sync.sv ***
// two-flop synchroniser for inputs from outside the core clock domain
`timescale 1ns/1ps
module dual_flop_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_regs_s;

  sync_regs_s r_q;
  sync_regs_s r_d;

  always_comb begin
    r_d.meta = async_i;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_o = r_q.stable;
endmodule // dual_flop_sync

// *** logic/sram_boundary_scan_tap.sv ***
// boundary-scan test port of the pipelined sram
`timescale 1ns/1ps
module sram_boundary_scan_tap
  import sram_tap_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire tap_pins_s tap_pins_i,
  input wire logic [`PIN_CELLS-1:0] pin_ring_i,
  input wire logic func_q_oe_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic pin_test_o,
  output logic [`PIN_CELLS-1:0] pin_drive_o,
  output logic q_bus_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and decode helpers

  tap_pins_s pins_s;
  logic [`PIN_CELLS-1:0] ring_s;

  dual_flop_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(tap_pins_i),
    .sync_o(pins_s)
  );

  dual_flop_sync #(
    .WIDTH(`PIN_CELLS)
  ) u_ring_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(pin_ring_i),
    .sync_o(ring_s)
  );

  // reserved codes fall back to the bypass path
  function automatic dr_sel_e dr_select(input logic [`IR_LEN-1:0] ir);
    case (ir)
      `IR_EXTEST: dr_select = DR_BSR;
      `IR_SAMPLE_Z: dr_select = DR_BSR;
      `IR_PRELOAD: dr_select = DR_BSR;
      `IR_IDCODE: dr_select = DR_ID;
      default: dr_select = DR_BYPASS;
    endcase
  endfunction

  function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
    case (s)
      TEST_LOGIC_RESET: tap_next = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: tap_next = tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_next = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_next = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: tap_next = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_next = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_next = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      default: tap_next = TEST_LOGIC_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // identification word

  logic [1:0] width_code;
  logic [`ID_CFG_MSB-`ID_CFG_LSB:0] part_cfg;
  logic [`ID_LEN-1:0] id_word;

  assign width_code = `ORG_IS_X36 ? `WIDTH_CODE_X36 : `WIDTH_CODE_X18;
  assign part_cfg = {1'h0, `ID_OPT_T, `ID_DENSITY, 1'h0, width_code, 2'h1,
                     `ID_OPT_P, `ID_OPT_Q, `ID_OPT_L, `ID_OPT_B, `ID_OPT_T,
                     `ID_OPT_S, 1'h0};
  assign id_word = {`ID_REVISION, part_cfg, `ID_VENDOR, `ID_START_BIT};

  ////////////////////////////////////////////////////////////////////////////
  // controller and registers

  tap_regs_s r_q;
  tap_regs_s r_d;
  logic tck_rise;
  logic tck_fall;
  dr_sel_e sel;
  logic [`IR_LEN-1:0] ir_next;

  assign tck_rise = pins_s.tck & ~r_q.tck_prev;
  assign tck_fall = ~pins_s.tck & r_q.tck_prev;
  assign sel = dr_select(r_q.ir);

  always_comb begin
    r_d = r_q;
    r_d.tck_prev = pins_s.tck;
    if (tck_rise) begin
      r_d.state = tap_next(r_q.state, pins_s.tms);
      case (r_q.state)
        CAPTURE_IR: begin
          r_d.ir_shift = `IR_CAPTURE_VAL;
        end
        SHIFT_IR: begin
          r_d.ir_shift = {pins_s.tdi, r_q.ir_shift[`IR_LEN-1:1]};
        end
        CAPTURE_DR: begin
          case (sel)
            DR_BSR: begin
              r_d.bsr_shift = {r_q.bsr_preload[`BSR_CTL_IDX], ring_s};
            end
            DR_ID: begin
              r_d.id_shift = id_word;
            end
            default: begin
              r_d.bypass = 1'h0;
            end
          endcase
        end
        SHIFT_DR: begin
          case (sel)
            DR_BSR: begin
              r_d.bsr_shift = {pins_s.tdi, r_q.bsr_shift[`BSR_LEN-1:1]};
            end
            DR_ID: begin
              r_d.id_shift = {pins_s.tdi, r_q.id_shift[`ID_LEN-1:1]};
            end
            default: begin
              r_d.bypass = pins_s.tdi;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      case (r_q.state)
        UPDATE_IR: begin
          r_d.ir = r_q.ir_shift;
        end
        UPDATE_DR: begin
          // preload stage, control cell included, only follows these two
          if (r_q.ir == `IR_EXTEST || r_q.ir == `IR_PRELOAD) begin
            r_d.bsr_preload = r_q.bsr_shift;
          end
        end
        TEST_LOGIC_RESET: begin
          r_d.ir = `IR_IDCODE;
        end
        default: begin
        end
      endcase
      // LSB leaves on the falling edge
      case (r_q.state)
        SHIFT_IR: begin
          r_d.tdo = r_q.ir_shift[0];
          r_d.tdo_oe = 1'h1;
        end
        SHIFT_DR: begin
          r_d.tdo_oe = 1'h1;
          case (sel)
            DR_BSR: r_d.tdo = r_q.bsr_shift[0];
            DR_ID: r_d.tdo = r_q.id_shift[0];
            default: r_d.tdo = r_q.bypass;
          endcase
        end
        default: begin
          r_d.tdo_oe = 1'h0;
        end
      endcase
    end
    // pin and read-bus control follow the current instruction
    r_d.pin_test = (r_q.ir == `IR_EXTEST);
    r_d.pin_drive = r_q.bsr_preload[`PIN_CELLS-1:0];
    case (r_q.ir)
      `IR_EXTEST: r_d.q_oe = r_q.bsr_preload[`BSR_CTL_IDX];
      `IR_SAMPLE_Z: r_d.q_oe = 1'h0;
      default: r_d.q_oe = func_q_oe_i;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q.state <= TEST_LOGIC_RESET;
      r_q.ir_shift <= `IR_CAPTURE_VAL;
      r_q.ir <= `IR_IDCODE;
      r_q.bsr_shift <= '0;
      r_q.bsr_preload <= '0;
      r_q.id_shift <= '0;
      r_q.bypass <= 1'h0;
      r_q.tck_prev <= 1'h0;
      r_q.tdo <= 1'h0;
      r_q.tdo_oe <= 1'h0;
      r_q.pin_test <= 1'h0;
      r_q.q_oe <= 1'h0;
      r_q.pin_drive <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign tdo_o = r_q.tdo;
  assign tdo_oe_o = r_q.tdo_oe;
  assign pin_test_o = r_q.pin_test;
  assign pin_drive_o = r_q.pin_drive;
  assign q_bus_oe_o = r_q.q_oe;

endmodule // sram_boundary_scan_tap

// *** logic/sram_tap_cfg.svh ***
// constants of the sram boundary-scan test port
`ifndef SRAM_TAP_CFG_SVH
`define SRAM_TAP_CFG_SVH

// scan chain geometry: position n of the exit order is bit n-1
`define BSR_LEN 109
`define PIN_CELLS 108
`define BSR_CTL_IDX 108

// instruction register
`define IR_LEN 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_PRELOAD 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_VAL 3'h1

// identification register layout
`define ID_LEN 32
`define ID_REV_MSB 31
`define ID_REV_LSB 29
`define ID_CFG_MSB 28
`define ID_CFG_LSB 12
`define ID_VEND_MSB 11
`define ID_VEND_LSB 1
`define ID_START_BIT 1'h1
// arbitrary revision and vendor values
`define ID_REVISION 3'h5
`define ID_VENDOR 11'h3c3
// part configuration subfields; density and option bits are arbitrary
`define ID_DENSITY 3'h1
`define ID_OPT_T 1'h0
`define ID_OPT_P 1'h0
`define ID_OPT_Q 1'h0
`define ID_OPT_L 1'h0
`define ID_OPT_B 1'h0
`define ID_OPT_S 1'h0
`define WIDTH_CODE_X36 2'h3
`define WIDTH_CODE_X18 2'h2
`define ORG_IS_X36 1'h1

`endif

// *** logic/sram_tap_pkg.sv ***
// types of the sram boundary-scan test port
package sram_tap_pkg;
`include "sram_tap_cfg.svh"

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    DR_BSR, DR_ID, DR_BYPASS
  } dr_sel_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_s;

  typedef struct packed {
    tap_state_e state;
    logic [`IR_LEN-1:0] ir_shift;
    logic [`IR_LEN-1:0] ir;
    logic [`BSR_LEN-1:0] bsr_shift;
    logic [`BSR_LEN-1:0] bsr_preload;
    logic [`ID_LEN-1:0] id_shift;
    logic bypass;
    logic tck_prev;
    logic tdo;
    logic tdo_oe;
    logic pin_test;
    logic q_oe;
    logic [`PIN_CELLS-1:0] pin_drive;
  } tap_regs_s;
endpackage

// *** test/jtag_host.sv ***
// board test controller model driving the link pins
`timescale 1ns/1ps
module jtag_host
  import sram_tap_pkg::*;
(
  input wire logic tdo_i,
  output tap_pins_s pins_o
);
  initial pins_o = 3'h3;
  // one 320 ns link period; tdo sampled just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    pins_o.tms = m;
    pins_o.tdi = d;
    #150 o = tdo_i;
    #10 pins_o.tck = 1'b1;
    #160 pins_o.tck = 1'b0;
  endtask
  task automatic tms_seq(input logic [7:0] s, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(s[i], 1'b1, o);
  endtask
  // from idle: shift n bits lsb first, pass update, back to idle
  task automatic scan(input logic ir, input logic [127:0] di, input int n,
                      output logic [127:0] dq);
    logic o;
    dq = '0;
    if (ir) tms_seq(8'h03, 4);
    else tms_seq(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], o);
      dq[i] = o;
    end
    tms_seq(8'h01, 2);
  endtask
endmodule // jtag_host

// *** test/sram_boundary_scan_tap_tb.sv ***
// self-checking bench of the sram boundary-scan test port
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb import sram_tap_pkg::*;;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error %0t: %h != %h", $time, (a), (b)); end end
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b1;
  logic func_q_oe_i = 1'b1;
  logic [`PIN_CELLS-1:0] ring = {27{4'h3}};
  tap_pins_s pins;
  logic tdo, tdo_oe, pin_test, q_oe;
  logic [`PIN_CELLS-1:0] drive;
  logic [127:0] dq;
  int n_mismatch = 0;
  int n_compared = 0;
  localparam logic [108:0] PRE = {1'b1, {27{4'hc}}};
  localparam logic [31:0] ID = {`ID_REVISION, 1'b0, `ID_OPT_T, `ID_DENSITY, 1'b0,
    `WIDTH_CODE_X36, 2'h1, `ID_OPT_P, `ID_OPT_Q, `ID_OPT_L, `ID_OPT_B, `ID_OPT_T,
    `ID_OPT_S, 1'b0, `ID_VENDOR, `ID_START_BIT};
  logic [2:0] codes [5] = '{`IR_EXTEST, `IR_SAMPLE_Z, `IR_PRELOAD, `IR_IDCODE, `IR_BYPASS};
  always #20 core_clk_i = ~core_clk_i;
  sram_boundary_scan_tap u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .tap_pins_i(pins), .pin_ring_i(ring), .func_q_oe_i(func_q_oe_i), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pin_test_o(pin_test), .pin_drive_o(drive), .q_bus_oe_o(q_oe));
  // a released tdo line shows the inverse of its last level
  jtag_host u_host (.tdo_i(tdo_oe ? tdo : ~tdo), .pins_o(pins));
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic ir(input logic [2:0] c);
    u_host.scan(1'b1, {125'h0, c}, 3, dq);
  endtask
  task automatic dr(input logic [127:0] d, input int n);
    u_host.scan(1'b0, d, n, dq);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2ms;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    // a real falling edge, so the flops are cleared before the first clock edge
    #1 rst_b_i = 1'b0;
    idle(10);
    rst_b_i = 1'b1;
    idle(4);
    u_host.tms_seq(8'h00, 1);
    func_q_oe_i = 1'b0;
    idle(8);
    `CHK(q_oe, 1'b0)
    func_q_oe_i = 1'b1;
    dr(128'h0, 32);
    `CHK(dq[31:0], ID)
    `CHK(dq[22:21], `WIDTH_CODE_X36)
    `CHK(tdo_oe, 1'b0)
    $display("test idcode done");
    foreach (codes[i]) begin
      ir(codes[i]);
      `CHK(dq[2:0], `IR_CAPTURE_VAL)
      `CHK(pin_test, codes[i] == `IR_EXTEST)
      `CHK(q_oe, codes[i] != `IR_EXTEST && codes[i] != `IR_SAMPLE_Z)
    end
    dr(128'h5a, 9);
    `CHK(dq[8:0], 9'h0b4)
    $display("test decode done");
    ir(`IR_PRELOAD);
    dr(PRE, 109);
    `CHK(dq[108:0], {1'b0, ring})
    `CHK(drive, PRE[107:0])
    func_q_oe_i = 1'b0;
    ir(`IR_EXTEST);
    `CHK({pin_test, q_oe}, 2'h3)
    func_q_oe_i = 1'b1;
    idle(8);
    dr({1'b0, PRE[107:0]}, 109);
    `CHK(dq[108:0], {1'b1, ring})
    `CHK(q_oe, 1'b0)
    dr(PRE, 109);
    `CHK(q_oe, 1'b1)
    ir(`IR_SAMPLE_Z);
    dr(128'h0, 109);
    ir(`IR_EXTEST);
    `CHK({q_oe, drive}, PRE)
    $display("test extest done");
    // from shift-dr, the deepest point, five tms-high rises must reach reset
    u_host.tms_seq(8'h01, 3);
    u_host.tms_seq(8'h1f, 6);
    `CHK(pin_test, 1'b0)
    dr(128'h0, 32);
    `CHK(dq[31:0], ID)
    ir(`IR_EXTEST);
    `CHK({q_oe, drive}, {2'h3, ring[107:1]})
    $display("test tap reset done");
    print_verdict();
  end
endmodule // sram_boundary_scan_tap_tb

// *** test/tap_props.sv ***
// port assertions of the sram boundary-scan test port
`timescale 1ns/1ps
module tap_props
  import sram_tap_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire tap_pins_s tap_pins_i,
  input wire logic [`PIN_CELLS-1:0] pin_ring_i,
  input wire logic func_q_oe_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic pin_test_o,
  input wire logic [`PIN_CELLS-1:0] pin_drive_o,
  input wire logic q_bus_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // link clock resting low long enough for any update to have landed
  sequence low_s;
    !tap_pins_i.tck [*6];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |->
    !tdo_oe_o && !pin_test_o && !q_bus_oe_o && pin_drive_o == '0)
    else $error("outputs active in reset");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(tap_pins_i.tck, 2))
    else $error("tdo moved outside low phase");
  a_drive_on_update: assert property ($changed(pin_drive_o) |-> !$past(tap_pins_i.tck, 2))
    else $error("preload moved outside low phase");
  a_test_on_fall: assert property ($changed(pin_test_o) |-> !$past(tap_pins_i.tck, 2))
    else $error("test mode moved outside low phase");
  a_idle_tdo_steady: assert property (low_s |-> $stable(tdo_o) && $stable(tdo_oe_o))
    else $error("tdo moved while idle");
  a_idle_pins_steady: assert property (low_s |-> $stable(pin_drive_o) && $stable(pin_test_o))
    else $error("pins moved while idle");
  a_q_follows: assert property (low_s ##0 (!pin_test_o && q_bus_oe_o) |=>
    q_bus_oe_o == $past(func_q_oe_i)) else $error("read bus not functional");
  a_q_ignores_func: assert property (low_s ##0 pin_test_o |=> $stable(q_bus_oe_o))
    else $error("read bus left test control");
endmodule // tap_props

bind sram_boundary_scan_tap tap_props u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .tap_pins_i(tap_pins_i), .pin_ring_i(pin_ring_i), .func_q_oe_i(func_q_oe_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_test_o(pin_test_o),
  .pin_drive_o(pin_drive_o), .q_bus_oe_o(q_bus_oe_o));
